// file: common/icid_map.svh
`ifndef ICID_MAP_SVH
`define ICID_MAP_SVH

// Register byte offsets
`define ICID_OFS_FIFTH       12'h0FD4
`define ICID_OFS_SIXTH       12'h0FD8
`define ICID_OFS_SEVENTH     12'h0FDC
`define ICID_OFS_EIGHTH      12'h0FC0
`define ICID_OFS_CLASS0      12'h0FF0
`define ICID_OFS_CLASS1      12'h0FF4
`define ICID_OFS_CLASS2      12'h0FF8
`define ICID_OFS_CLASS3      12'h0FFC

// Widths
`define ICID_ADDR_W          12
`define ICID_SPI_W           10
`define ICID_PPI_W           5

// Largest legal codes; anything above is reserved
`define ICID_SPI_MAX         10'h3DC
`define ICID_PPI_MAX         5'h10
`define ICID_PRIO_MAX        3'h4

// Default configuration
`define ICID_SPI_DEF         10'h020
`define ICID_PPI_DEF         5'h10
`define ICID_SGI_DEF         5'h10
`define ICID_PRIO_DEF        3'h4
`define ICID_CPUIF_DEF       3'h0
// Arbitrary component identifier, not tied to any maker
`define ICID_CLASS_ID_DEF    32'h1234_5678

// Bus responses and reserved fill
`define ICID_RESP_OKAY       2'h0
`define ICID_RESP_SLVERR     2'h2
`define ICID_UPPER_FILL      24'h00_0000

`endif

// file: common/icid_pkg.sv
package icid_pkg;
	typedef enum logic [1:0] {
		ICID_PROTO_AXI = 2'b00,
		ICID_PROTO_AHB = 2'b01
	} icid_proto_e;

	typedef enum logic [0:0] {
		ICID_SPACE_DIST  = 1'b0,
		ICID_SPACE_CPUIF = 1'b1
	} icid_space_e;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        aw_held;
		logic        w_held;
		logic        wr_hit;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} icid_state_s;
endpackage

// file: logic/icid_regs.sv
`include "icid_map.svh"

// Notes on behaviour
// - Ident registers return fixed low byte
// - Sixth: shared low six, private high two
// - Seventh low nibble: shared count high bits
// - Seventh bit 7: dual security support
// - Seventh bits 6:4: priority level code
// - Eighth bit 7: distributor zero, interface one
// - Eighth bits 6:5: bus protocol code
// - Eighth bits 4:2: interfaces minus one
// - Eighth bit 1: bypass fast input present
// - Eighth bit 0: bypass normal input present
// - Four class bytes, byte three highest
// - Class bytes unreachable while held in reset
// - Shared count: 1..988 valid codes
// - Private count low bits in fifth register
module icid_regs #(
	parameter logic [`ICID_SPI_W-1:0] SHARED_COUNT   = `ICID_SPI_DEF,
	parameter logic [`ICID_PPI_W-1:0] PRIVATE_COUNT  = `ICID_PPI_DEF,
	parameter logic [4:0]             SOFT_COUNT     = `ICID_SGI_DEF,
	parameter logic                   DUAL_SECURITY  = 1'b1,
	parameter logic [2:0]             PRIORITY_CODE  = `ICID_PRIO_DEF,
	parameter icid_pkg::icid_space_e  REG_SPACE      = icid_pkg::ICID_SPACE_DIST,
	parameter icid_pkg::icid_proto_e  BUS_PROTOCOL   = icid_pkg::ICID_PROTO_AXI,
	parameter logic [2:0]             CPU_IF_M1      = `ICID_CPUIF_DEF,
	parameter logic                   BYPASS_FAST    = 1'b0,
	parameter logic                   BYPASS_NORMAL  = 1'b0,
	parameter logic [31:0]            CLASS_ID       = `ICID_CLASS_ID_DEF
) (
	// Clock and reset
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	// Write address
	input  wire logic                    awvalid,
	output logic                         awready,
	input  wire logic [`ICID_ADDR_W-1:0] awaddr,
	input  wire logic [2:0]              awprot,
	// Write data
	input  wire logic                    wvalid,
	output logic                         wready,
	input  wire logic [31:0]             wdata,
	input  wire logic [3:0]              wstrb,
	// Write response
	output logic                         bvalid,
	input  wire logic                    bready,
	output logic [1:0]                   bresp,
	// Read address
	input  wire logic                    arvalid,
	output logic                         arready,
	input  wire logic [`ICID_ADDR_W-1:0] araddr,
	input  wire logic [2:0]              arprot,
	// Read data
	output logic                         rvalid,
	input  wire logic                    rready,
	output logic [31:0]                  rdata,
	output logic [1:0]                   rresp
);

	// ------------------------------------------------------------
	// Fixed register images
	// ------------------------------------------------------------
	logic [7:0] img_fifth;
	logic [7:0] img_sixth;
	logic [7:0] img_seventh;
	logic [7:0] img_eighth;
	logic [7:0] img_class [4];

	assign img_fifth   = {PRIVATE_COUNT[2:0], SOFT_COUNT};
	assign img_sixth   = {SHARED_COUNT[5:0], PRIVATE_COUNT[4:3]};
	assign img_seventh = {DUAL_SECURITY, PRIORITY_CODE, SHARED_COUNT[9:6]};
	assign img_eighth  = {REG_SPACE, BUS_PROTOCOL, CPU_IF_M1,
	                      BYPASS_FAST, BYPASS_NORMAL};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_class
			assign img_class[gi] = CLASS_ID[gi*8 +: 8];
		end
	endgenerate

	// ------------------------------------------------------------
	// Read decode
	// ------------------------------------------------------------
	logic       rd_hit;
	logic [7:0] rd_byte;

	always_comb begin
		rd_hit  = 1'b1;
		rd_byte = 8'h00;
		unique case (araddr)
			`ICID_OFS_FIFTH:   rd_byte = img_fifth;
			`ICID_OFS_SIXTH:   rd_byte = img_sixth;
			`ICID_OFS_SEVENTH: rd_byte = img_seventh;
			`ICID_OFS_EIGHTH:  rd_byte = img_eighth;
			`ICID_OFS_CLASS0:  rd_byte = img_class[0];
			`ICID_OFS_CLASS1:  rd_byte = img_class[1];
			`ICID_OFS_CLASS2:  rd_byte = img_class[2];
			`ICID_OFS_CLASS3:  rd_byte = img_class[3];
			default:           rd_hit  = 1'b0;
		endcase
	end

	logic wr_hit;
	always_comb begin
		unique case (awaddr)
			`ICID_OFS_FIFTH, `ICID_OFS_SIXTH, `ICID_OFS_SEVENTH, `ICID_OFS_EIGHTH,
			`ICID_OFS_CLASS0, `ICID_OFS_CLASS1, `ICID_OFS_CLASS2, `ICID_OFS_CLASS3:
				wr_hit = 1'b1;
			default:
				wr_hit = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// Bus slave state
	// ------------------------------------------------------------
	icid_pkg::icid_state_s st_r;
	icid_pkg::icid_state_s st_nxt;
	logic                  aw_take;
	logic                  w_take;
	logic                  ar_take;

	assign aw_take = awvalid && st_r.awready;
	assign w_take  = wvalid && st_r.wready;
	assign ar_take = arvalid && st_r.arready;

	always_comb begin
		st_nxt = st_r;
		// All-clear only follows reset: channels open one cycle after release
		if (!(st_r.awready || st_r.wready || st_r.arready || st_r.aw_held
		      || st_r.w_held || st_r.bvalid || st_r.rvalid)) begin
			st_nxt.awready = 1'b1;
			st_nxt.wready  = 1'b1;
			st_nxt.arready = 1'b1;
		end
		// Address and data may come in either order; each is held until its partner arrives
		if (aw_take) begin
			st_nxt.aw_held = 1'b1;
			st_nxt.awready = 1'b0;
			st_nxt.wr_hit  = wr_hit;
		end
		if (w_take) begin
			st_nxt.w_held = 1'b1;
			st_nxt.wready = 1'b0;
		end
		// Writes never reach any storage: read-only bank just acknowledges
		if ((st_r.aw_held || aw_take) && (st_r.w_held || w_take) && !st_r.bvalid) begin
			st_nxt.bvalid  = 1'b1;
			st_nxt.bresp   = (aw_take ? wr_hit : st_r.wr_hit) ? `ICID_RESP_OKAY : `ICID_RESP_SLVERR;
			st_nxt.aw_held = 1'b0;
			st_nxt.w_held  = 1'b0;
		end
		if (st_r.bvalid && bready) begin
			st_nxt.bvalid  = 1'b0;
			st_nxt.awready = 1'b1;
			st_nxt.wready  = 1'b1;
		end
		if (ar_take) begin
			st_nxt.arready = 1'b0;
			st_nxt.rvalid  = 1'b1;
			// Upper bits are undefined; zero is the cheapest stable choice
			st_nxt.rdata   = {`ICID_UPPER_FILL, rd_byte};
			st_nxt.rresp   = rd_hit ? `ICID_RESP_OKAY : `ICID_RESP_SLVERR;
		end
		if (st_r.rvalid && rready) begin
			st_nxt.rvalid  = 1'b0;
			st_nxt.arready = 1'b1;
		end
	end

	// Ready stays low during reset, so nothing is accepted then
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign awready = st_r.awready;
	assign wready  = st_r.wready;
	assign bvalid  = st_r.bvalid;
	assign bresp   = st_r.bresp;
	assign arready = st_r.arready;
	assign rvalid  = st_r.rvalid;
	assign rdata   = st_r.rdata;
	assign rresp   = st_r.rresp;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_read_req;
		arvalid && arready;
	endsequence

	sequence s_read_done;
		rvalid && rready;
	endsequence

	sequence s_write_req;
		awvalid && awready && wvalid && wready;
	endsequence

	sequence s_write_done;
		bvalid && bready;
	endsequence

	sequence s_aw_only;
		awvalid && awready && !(wvalid && wready);
	endsequence

	sequence s_w_only;
		wvalid && wready && !(awvalid && awready);
	endsequence

	// ------------------------------------------------------------
	// Read channel checks
	// ------------------------------------------------------------
	a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		s_read_req |=> rvalid && !arready)
		else $error("read not answered next cycle");
	a_read_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
		rvalid |-> !arready)
		else $error("read accepted while one is outstanding");
	a_resp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
	a_rresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		rvalid && !rready |=> $stable(rresp))
		else $error("read response changed while waiting");
	a_read_release: assert property (@(posedge aclk) disable iff (!aresetn)
		s_read_done |=> !rvalid && arready)
		else $error("read channel not reopened");
	a_hit_okay: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_read_req and rd_hit) |=> rresp == `ICID_RESP_OKAY)
		else $error("mapped read not okay");
	a_miss_error: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_read_req and !rd_hit) |=> rresp == `ICID_RESP_SLVERR && rdata == '0)
		else $error("unmapped read not refused");
	a_upper_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		rvalid |-> rdata[31:8] == `ICID_UPPER_FILL)
		else $error("upper read bits not zero");

	// ------------------------------------------------------------
	// Register content checks
	// ------------------------------------------------------------
	a_fifth_val: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_read_req and (araddr == `ICID_OFS_FIFTH)) |=> rdata[7:5] == PRIVATE_COUNT[2:0])
		else $error("fifth register private bits wrong");
	a_fifth_soft: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_read_req and (araddr == `ICID_OFS_FIFTH)) |=> rdata[4:0] == SOFT_COUNT)
		else $error("fifth register low bits wrong");
	a_sixth_val: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_read_req and (araddr == `ICID_OFS_SIXTH)) |=> rdata[7:0] == {SHARED_COUNT[5:0], PRIVATE_COUNT[4:3]})
		else $error("sixth register wrong");
	a_sixth_shared: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_read_req and (araddr == `ICID_OFS_SIXTH)) |=> rdata[7:2] == SHARED_COUNT[5:0])
		else $error("sixth register shared bits wrong");
	a_sixth_private: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_read_req and (araddr == `ICID_OFS_SIXTH)) |=> rdata[1:0] == PRIVATE_COUNT[4:3])
		else $error("sixth register private bits wrong");
	a_seventh_val: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_read_req and (araddr == `ICID_OFS_SEVENTH)) |=> rdata[3:0] == SHARED_COUNT[9:6])
		else $error("seventh register wrong");
	a_seventh_secure: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_read_req and (araddr == `ICID_OFS_SEVENTH)) |=> rdata[7] == DUAL_SECURITY)
		else $error("security bit wrong");
	a_seventh_prio: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_read_req and (araddr == `ICID_OFS_SEVENTH)) |=> rdata[6:4] == PRIORITY_CODE)
		else $error("priority code wrong");
	a_eighth_val: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_read_req and (araddr == `ICID_OFS_EIGHTH)) |=> rdata[7:0] == {REG_SPACE, BUS_PROTOCOL, CPU_IF_M1,
		BYPASS_FAST, BYPASS_NORMAL}) else $error("eighth register wrong");
	a_eighth_space: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_read_req and (araddr == `ICID_OFS_EIGHTH)) |=> rdata[7] == REG_SPACE)
		else $error("register space bit wrong");
	a_eighth_proto: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_read_req and (araddr == `ICID_OFS_EIGHTH)) |=> rdata[6:5] == BUS_PROTOCOL)
		else $error("protocol code wrong");
	a_eighth_cpus: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_read_req and (araddr == `ICID_OFS_EIGHTH)) |=> rdata[4:2] == CPU_IF_M1)
		else $error("interface count wrong");
	a_eighth_fast: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_read_req and (araddr == `ICID_OFS_EIGHTH)) |=> rdata[1] == BYPASS_FAST)
		else $error("fast bypass bit wrong");
	a_eighth_normal: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_read_req and (araddr == `ICID_OFS_EIGHTH)) |=> rdata[0] == BYPASS_NORMAL)
		else $error("normal bypass bit wrong");
	a_class_low: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_read_req and (araddr == `ICID_OFS_CLASS0)) |=> rdata[7:0] == CLASS_ID[7:0])
		else $error("class byte zero wrong");
	a_class_one: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_read_req and (araddr == `ICID_OFS_CLASS1)) |=> rdata[7:0] == CLASS_ID[15:8])
		else $error("class byte one wrong");
	a_class_two: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_read_req and (araddr == `ICID_OFS_CLASS2)) |=> rdata[7:0] == CLASS_ID[23:16])
		else $error("class byte two wrong");
	a_class_top: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_read_req and (araddr == `ICID_OFS_CLASS3)) |=> rdata[7:0] == CLASS_ID[31:24])
		else $error("class byte three wrong");
	// Configuration codes are static, so a reserved code is caught at the first read
	a_spi_legal: assert property (@(posedge aclk) disable iff (!aresetn)
		s_read_req |-> SHARED_COUNT != '0 && SHARED_COUNT <= `ICID_SPI_MAX)
		else $error("shared count code reserved");
	a_ppi_legal: assert property (@(posedge aclk) disable iff (!aresetn)
		s_read_req |-> PRIVATE_COUNT <= `ICID_PPI_MAX)
		else $error("private count code reserved");
	a_prio_legal: assert property (@(posedge aclk) disable iff (!aresetn)
		s_read_req |-> PRIORITY_CODE <= `ICID_PRIO_MAX)
		else $error("priority code reserved");
	a_proto_legal: assert property (@(posedge aclk) disable iff (!aresetn)
		s_read_req |-> BUS_PROTOCOL == icid_pkg::ICID_PROTO_AXI || BUS_PROTOCOL == icid_pkg::ICID_PROTO_AHB)
		else $error("protocol code reserved");

	// ------------------------------------------------------------
	// Write channel checks
	// ------------------------------------------------------------
	a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
		s_write_req |=> bvalid && !awready && !wready)
		else $error("write not answered");
	a_write_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
		bvalid |-> !awready && !wready)
		else $error("write accepted while response pending");
	a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	a_write_release: assert property (@(posedge aclk) disable iff (!aresetn)
		s_write_done |=> !bvalid && awready && wready)
		else $error("write channel not reopened");
	a_write_okay: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_write_req and wr_hit) |=> bresp == `ICID_RESP_OKAY)
		else $error("mapped write not okay");
	a_write_error: assert property (@(posedge aclk) disable iff (!aresetn)
		(s_write_req and !wr_hit) |=> bresp == `ICID_RESP_SLVERR)
		else $error("unmapped write not refused");
	a_aw_first: assert property (@(posedge aclk) disable iff (!aresetn)
		s_aw_only |=> !awready)
		else $error("address taken twice");
	a_w_first: assert property (@(posedge aclk) disable iff (!aresetn)
		s_w_only |=> !wready)
		else $error("data taken twice");

	// ------------------------------------------------------------
	// Reset checks
	// ------------------------------------------------------------
	a_reset_quiet: assert property (@(posedge aclk)
		!aresetn |=> !awready && !arready && !wready)
		else $error("ready during reset");
	a_reset_idle: assert property (@(posedge aclk)
		!aresetn |=> !rvalid && !bvalid)
		else $error("response during reset");
	a_ready_return: assert property (@(posedge aclk)
		!aresetn ##1 aresetn |=> awready && wready && arready)
		else $error("channels not opened after reset");

endmodule

// file: tb/tb_top.sv
`include "icid_map.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [11:0] a; logic [31:0] d; logic [1:0] r;} icid_row_s;
	// Non-default settings, so that swapped or shifted fields show up
	localparam logic [9:0]  SC  = 10'h2B5;
	localparam logic [4:0]  PC  = 5'h0B;
	localparam logic [4:0]  GC  = 5'h07;
	localparam logic [2:0]  PR  = 3'h3;
	localparam logic [2:0]  CI  = 3'h5;
	// Arbitrary identifier value
	localparam logic [31:0] CID = 32'hA5C3_1E69;
	logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [2:0]  awprot = 0, arprot = 0;
	logic [31:0] wdata = 0, rdata;
	logic [3:0]  wstrb = 0;
	logic [1:0]  bresp, rresp;
	int          errors = 0, n_checks = 0;
	icid_row_s   rows [9];

	always #10 aclk = ~aclk;

	icid_regs #(.SHARED_COUNT(SC), .PRIVATE_COUNT(PC), .SOFT_COUNT(GC), .DUAL_SECURITY(1'b1), .PRIORITY_CODE(PR),
		.REG_SPACE(icid_pkg::ICID_SPACE_CPUIF), .BUS_PROTOCOL(icid_pkg::ICID_PROTO_AHB), .CPU_IF_M1(CI),
		.BYPASS_FAST(1'b1), .BYPASS_NORMAL(1'b0), .CLASS_ID(CID)) u_icid_regs (
		.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// Ready lines stay high between transfers, so no line is driven twice in one step
	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		arvalid <= 1'b1;
		araddr  <= a;
		rready  <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
	endtask

	task automatic axi_wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] r);
		logic ga;
		logic gw;
		ga = 1'b0;
		gw = 1'b0;
		awvalid <= 1'b1;
		awaddr  <= a;
		wvalid  <= 1'b1;
		wdata   <= v;
		wstrb   <= 4'hF;
		bready  <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) begin
				awvalid <= 1'b0;
				ga = 1'b1;
			end
			if (wready === 1'b1) begin
				wvalid <= 1'b0;
				gw = 1'b1;
			end
		end while (!(ga && gw));
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
	endtask

	task automatic run_table();
		logic [31:0] d;
		logic [1:0]  r;
		for (int i = 0; i < 9; i++) begin
			axi_rd(rows[i].a, d, r);
			chk(d, rows[i].d);
			chk({30'h0, r}, {30'h0, rows[i].r});
		end
	endtask

	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (3000) @(posedge aclk);
		errors++;
		report_and_stop();
	end

	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		rows[0] = '{`ICID_OFS_FIFTH, {24'h0, PC[2:0], GC}, 2'h0};
		rows[1] = '{`ICID_OFS_SIXTH, {24'h0, SC[5:0], PC[4:3]}, 2'h0};
		rows[2] = '{`ICID_OFS_SEVENTH, {24'h0, 1'b1, PR, SC[9:6]}, 2'h0};
		rows[3] = '{`ICID_OFS_EIGHTH, {24'h0, 1'b1, 2'b01, CI, 1'b1, 1'b0}, 2'h0};
		rows[4] = '{`ICID_OFS_CLASS0, {24'h0, CID[7:0]}, 2'h0};
		rows[5] = '{`ICID_OFS_CLASS1, {24'h0, CID[15:8]}, 2'h0};
		rows[6] = '{`ICID_OFS_CLASS2, {24'h0, CID[23:16]}, 2'h0};
		rows[7] = '{`ICID_OFS_CLASS3, {24'h0, CID[31:24]}, 2'h0};
		rows[8] = '{12'hFC4, 32'h0, 2'h2};
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		run_table();
		$display("test table done");
		for (int i = 0; i < 9; i++) begin
			axi_wr(rows[i].a, 32'hFFFF_FFFF, r);
			chk({30'h0, r}, {30'h0, rows[i].r});
		end
		run_table();
		$display("test write done");
		// Read pending across a reset must never be accepted
		aresetn <= 1'b0;
		arvalid <= 1'b1;
		araddr  <= `ICID_OFS_CLASS3;
		repeat (5) begin
			@(posedge aclk);
			#1 chk({30'h0, arready, rvalid}, 32'h0);
		end
		@(posedge aclk);
		arvalid <= 1'b0;
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		axi_rd(`ICID_OFS_CLASS3, d, r);
		chk(d, {24'h0, CID[31:24]});
		$display("test reset done");
		report_and_stop();
	end
endmodule
